//--- core/usffl_consts.vh
// Purpose: Constants for the soft flow control and FIFO level block.
// Assumes: Included by core/usffl_core.v and by the checker and bench under dv.
// Notes:   Offsets are register indices on the plain register port.
`ifndef USFFL_CONSTS_VH
`define USFFL_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define USFFL_OFF_FEATURE   5'h09
`define USFFL_OFF_TX_TRIG   5'h0a
`define USFFL_OFF_RX_LVL    5'h0b
`define USFFL_OFF_PAUSE1    5'h0c
`define USFFL_OFF_PAUSE2    5'h0d
`define USFFL_OFF_RESUME1   5'h0e
`define USFFL_OFF_RESUME2   5'h0f
`define USFFL_OFF_TX_CNT    5'h10

// ****************************************************************
// Field positions and values
// ****************************************************************
`define USFFL_SEL_TX_HI     3
`define USFFL_SEL_TX_LO     2
`define USFFL_SEL_RX_HI     1
`define USFFL_SEL_RX_LO     0
`define USFFL_SEL_OFF       2'h0
`define USFFL_SEL_SECOND    2'h1
`define USFFL_SEL_FIRST     2'h2
`define USFFL_SEL_BOTH      2'h3
`define USFFL_STS_PAUSE1    0
`define USFFL_STS_RESUME1   1
`define USFFL_STS_PAUSE2    2
`define USFFL_STS_RESUME2   3

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define USFFL_RST_BYTE      8'h00
`define USFFL_TRIG_MAX      8'h40
`define USFFL_FIFO_DEPTH    8'h40

`endif

//--- core/usffl_core.v
// Purpose: Soft flow control character selection, sending and matching,
//          plus transmit and receive FIFO fill counters and trigger levels.
// Assumes: All inputs come from logic on ref_clk; the serializer takes one
//          flow character per handshake and the FIFOs report push and pop.
// Notes:   Bits 7:4 of the feature register are stored and read back only.
//
// Behaviour
// - Flow control select is feature register bits 3:0, offset 09, reset zero.
// - Transmit select 00: no pause or resume characters are sent.
// - Transmit select 10: send first resume and first pause characters.
// - Transmit select 01: send second resume and second pause characters.
// - Transmit select 11: send two-character resume and pause sequences.
// - Receive select 00: incoming characters are not compared.
// - Receive select 10: compare against first resume and first pause.
// - Receive select 01: compare against second resume and second pause.
// - Select 1011: send first characters, accept either resume or pause.
// - Select 0111: send second characters, accept either resume or pause.
// - Select 1111: send and match both characters of each sequence.
// - Select 0011: send nothing, match two-character resume and pause sequences.
// - Read-only eight-bit transmit fill count; writes do not change it.
// - Write-only transmit trigger at 0A, accepted from 0x00 to 0x40.
// - Offset 0B reads receive fill count and writes receive trigger.
// - Receive trigger writes limited to 0x00 through 0x40.
// - Offset 0C writes first pause character, reads sent-character status.
// - Status bits 3,1 resume sent, 2,0 pause sent, 7:4 read zero.
// - Second pause, first and second resume at 0D, 0E, 0F, reset zero.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "usffl_consts.vh"

module usffl_core #(
  parameter CNT_W = 8
) (
  // Clock and reset.
  input  wire             ref_clk,
  input  wire             rst_n,
  // Register port.
  input  wire [4:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  // FIFO occupancy events.
  input  wire             tx_push,
  input  wire             tx_pop,
  input  wire             rx_push,
  input  wire             rx_pop,
  // Received characters from the deserializer.
  input  wire             rx_char_valid,
  input  wire [7:0]       rx_char_data,
  // Flow characters towards the serializer.
  output reg              flow_char_valid,
  output reg  [7:0]       flow_char_data,
  input  wire             flow_char_taken,
  // Status towards the UART core.
  output reg              tx_halt,
  output reg              rx_flow_hit,
  output reg              tx_at_trigger,
  output reg              rx_at_trigger
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [7:0]       feature_ff;
  reg [7:0]       tx_trig_ff;
  reg [7:0]       rx_trig_ff;
  reg [7:0]       pause1_ff;
  reg [7:0]       pause2_ff;
  reg [7:0]       resume1_ff;
  reg [7:0]       resume2_ff;
  reg [3:0]       sent_sts_ff;
  reg [CNT_W-1:0] tx_cnt_ff;
  reg [CNT_W-1:0] rx_cnt_ff;

  // Both select fields come straight from the stored feature byte, so a new
  // selection acts from the cycle after its write.
  wire [1:0] tx_sel = feature_ff[`USFFL_SEL_TX_HI:`USFFL_SEL_TX_LO];
  wire [1:0] rx_sel = feature_ff[`USFFL_SEL_RX_HI:`USFFL_SEL_RX_LO];

  // Clamp a trigger write; anything past the FIFO depth is meaningless.
  // Clamping rather than ignoring the write gives software that asks for too
  // much the deepest level the FIFO can reach.
  wire [7:0] trig_wval = (reg_wdata > `USFFL_TRIG_MAX) ? `USFFL_TRIG_MAX
                                                       : reg_wdata;

  // Host writes; unmapped offsets are ignored.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      feature_ff <= `USFFL_RST_BYTE;
      tx_trig_ff <= `USFFL_RST_BYTE;
      rx_trig_ff <= `USFFL_RST_BYTE;
      pause1_ff  <= `USFFL_RST_BYTE;
      pause2_ff  <= `USFFL_RST_BYTE;
      resume1_ff <= `USFFL_RST_BYTE;
      resume2_ff <= `USFFL_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `USFFL_OFF_FEATURE: feature_ff <= reg_wdata;
        `USFFL_OFF_TX_TRIG: tx_trig_ff <= trig_wval;
        `USFFL_OFF_RX_LVL:  rx_trig_ff <= trig_wval;
        `USFFL_OFF_PAUSE1:  pause1_ff  <= reg_wdata;
        `USFFL_OFF_PAUSE2:  pause2_ff  <= reg_wdata;
        `USFFL_OFF_RESUME1: resume1_ff <= reg_wdata;
        `USFFL_OFF_RESUME2: resume2_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  reg [7:0] nxt_rdata;

  // Read data is registered so it stands only in the cycle after the strobe.
  // Zero outside that cycle keeps a shared read mux quiet, at the cost of
  // one cycle of latency on every read.
  always @* begin
    nxt_rdata = `USFFL_RST_BYTE;
    case (reg_addr)
      `USFFL_OFF_FEATURE: nxt_rdata = feature_ff;
      `USFFL_OFF_RX_LVL:  nxt_rdata = rx_cnt_ff;
      `USFFL_OFF_PAUSE1:  nxt_rdata = {4'h0, sent_sts_ff};
      `USFFL_OFF_TX_CNT:  nxt_rdata = tx_cnt_ff;
      default:            nxt_rdata = `USFFL_RST_BYTE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= `USFFL_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= `USFFL_RST_BYTE;
    end
  end

  // ****************************************************************
  // FIFO fill counters
  // ****************************************************************
  // A push into a full FIFO or a pop from an empty one is ignored, so the
  // counters never wrap; a push and pop that are both kept leave the count alone.
  wire tx_inc = tx_push && (tx_cnt_ff != `USFFL_FIFO_DEPTH);
  wire tx_dec = tx_pop  && (tx_cnt_ff != {CNT_W{1'b0}});
  wire rx_inc = rx_push && (rx_cnt_ff != `USFFL_FIFO_DEPTH);
  wire rx_dec = rx_pop  && (rx_cnt_ff != {CNT_W{1'b0}});

  // Counts change only on FIFO traffic, never on a register write.
  // The limit is the FIFO depth, not the counter width, so a wider CNT_W
  // never lets a count run past a full FIFO.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_cnt_ff <= {CNT_W{1'b0}};
      rx_cnt_ff <= {CNT_W{1'b0}};
    end else begin
      if (tx_inc && !tx_dec) begin
        tx_cnt_ff <= tx_cnt_ff + 1'b1;
      end else if (tx_dec && !tx_inc) begin
        tx_cnt_ff <= tx_cnt_ff - 1'b1;
      end
      if (rx_inc && !rx_dec) begin
        rx_cnt_ff <= rx_cnt_ff + 1'b1;
      end else if (rx_dec && !rx_inc) begin
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
      end
    end
  end

  // Trigger flags: transmit asks for data at or below its level, receive
  // reports data at or above its level.
  // The flags lag the counts by one cycle; a user that needs the exact
  // cycle must compare the counts directly.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_at_trigger <= 1'b0;
      rx_at_trigger <= 1'b0;
    end else begin
      tx_at_trigger <= (tx_cnt_ff <= tx_trig_ff);
      rx_at_trigger <= (rx_cnt_ff >= rx_trig_ff);
    end
  end

  // ****************************************************************
  // Outgoing flow characters
  // ****************************************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FIRST = 2'h1;
  localparam [1:0] ST_SECND = 2'h2;
  // The unused fourth code falls back to idle with the offer withdrawn, so
  // an upset never leaves a stale character offered.

  reg [1:0] tx_state_ff;
  reg       told_pause_ff;
  reg       send_pause_ff;
  reg [1:0] nxt_state;
  reg       nxt_valid;
  reg [7:0] nxt_char;
  reg       nxt_told;
  reg [3:0] nxt_sts;

  wire tx_fc_on   = (tx_sel != `USFFL_SEL_OFF);
  wire want_pause = (rx_cnt_ff >= rx_trig_ff);
  wire two_char   = (tx_sel == `USFFL_SEL_BOTH);
  wire use_second = (tx_sel == `USFFL_SEL_SECOND);

  // First character of the pending sequence for the selected mode.
  wire [7:0] first_pause  = use_second ? pause2_ff  : pause1_ff;
  wire [7:0] first_resume = use_second ? resume2_ff : resume1_ff;

  // The state machine sends one pause or resume sequence whenever the wanted
  // remote state differs from what was last told; a level that swings back
  // mid-sequence is picked up after the sequence completes.
  always @* begin
    nxt_state = tx_state_ff;
    nxt_valid = flow_char_valid;
    nxt_char  = flow_char_data;
    nxt_told  = told_pause_ff;
    nxt_sts   = sent_sts_ff;
    case (tx_state_ff)
      ST_IDLE: begin
        if (!tx_fc_on) begin
          nxt_told = 1'b0;
        end else if (want_pause != told_pause_ff) begin
          nxt_valid = 1'b1;
          nxt_char  = want_pause ? first_pause : first_resume;
          nxt_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (flow_char_taken) begin
          if (send_pause_ff) begin
            nxt_sts[`USFFL_STS_PAUSE1 + {use_second, 1'b0}]  = 1'b1;
            nxt_sts[`USFFL_STS_RESUME1 + {use_second, 1'b0}] = 1'b0;
          end else begin
            nxt_sts[`USFFL_STS_RESUME1 + {use_second, 1'b0}] = 1'b1;
            nxt_sts[`USFFL_STS_PAUSE1 + {use_second, 1'b0}]  = 1'b0;
          end
          if (two_char) begin
            nxt_char  = send_pause_ff ? pause2_ff : resume2_ff;
            nxt_state = ST_SECND;
          end else begin
            nxt_valid = 1'b0;
            nxt_told  = send_pause_ff;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_SECND: begin
        if (flow_char_taken) begin
          if (send_pause_ff) begin
            nxt_sts[`USFFL_STS_PAUSE2]  = 1'b1;
            nxt_sts[`USFFL_STS_RESUME2] = 1'b0;
          end else begin
            nxt_sts[`USFFL_STS_RESUME2] = 1'b1;
            nxt_sts[`USFFL_STS_PAUSE2]  = 1'b0;
          end
          nxt_valid = 1'b0;
          nxt_told  = send_pause_ff;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_valid = 1'b0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sender registers. The pause or resume choice is latched only while idle,
  // so a sequence always ends with the kind of character it began with.
  // Status bits are sticky: only the opposite character sent clears them.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_state_ff     <= ST_IDLE;
      flow_char_valid <= 1'b0;
      flow_char_data  <= `USFFL_RST_BYTE;
      told_pause_ff   <= 1'b0;
      send_pause_ff   <= 1'b0;
      sent_sts_ff     <= 4'h0;
    end else begin
      tx_state_ff     <= nxt_state;
      flow_char_valid <= nxt_valid;
      flow_char_data  <= nxt_char;
      told_pause_ff   <= nxt_told;
      sent_sts_ff     <= nxt_sts;
      if (tx_state_ff == ST_IDLE) begin
        send_pause_ff <= want_pause;
      end
    end
  end

  // ****************************************************************
  // Incoming flow character matching
  // ****************************************************************
  // Memory of a first sequence character; any other valid character clears
  // it, so both halves of a sequence must arrive back to back.
  reg prev_resume1_ff;
  reg prev_pause1_ff;

  // Either-character acceptance applies when the transmit side sends single
  // characters; otherwise select 11 matches two-character sequences.
  wire rx_either = (rx_sel == `USFFL_SEL_BOTH) &&
                   ((tx_sel == `USFFL_SEL_FIRST) ||
                    (tx_sel == `USFFL_SEL_SECOND));
  wire rx_seq    = (rx_sel == `USFFL_SEL_BOTH) && !rx_either;

  // Raw compares against every stored character; the mode picks which count.
  wire eq_p1 = (rx_char_data == pause1_ff);
  wire eq_p2 = (rx_char_data == pause2_ff);
  wire eq_r1 = (rx_char_data == resume1_ff);
  wire eq_r2 = (rx_char_data == resume2_ff);

  reg hit_pause;
  reg hit_resume;

  // Classify each received character for the selected receive mode.
  always @* begin
    hit_pause  = 1'b0;
    hit_resume = 1'b0;
    case (rx_sel)
      `USFFL_SEL_OFF: begin
        hit_pause  = 1'b0;
        hit_resume = 1'b0;
      end
      `USFFL_SEL_FIRST: begin
        hit_pause  = eq_p1;
        hit_resume = eq_r1;
      end
      `USFFL_SEL_SECOND: begin
        hit_pause  = eq_p2;
        hit_resume = eq_r2;
      end
      default: begin
        if (rx_seq) begin
          hit_pause  = prev_pause1_ff  && eq_p2;
          hit_resume = prev_resume1_ff && eq_r2;
        end else begin
          hit_pause  = eq_p1 || eq_p2;
          hit_resume = eq_r1 || eq_r2;
        end
      end
    endcase
  end

  // A matched pause halts the transmitter once its current character ends;
  // the serializer samples tx_halt only between characters.
  // Turning receive compares off also releases the halt, so software can
  // always recover a transmitter stuck by a lost resume character.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_halt         <= 1'b0;
      rx_flow_hit     <= 1'b0;
      prev_pause1_ff  <= 1'b0;
      prev_resume1_ff <= 1'b0;
    end else begin
      rx_flow_hit <= rx_char_valid && (hit_pause || hit_resume);
      if (rx_sel == `USFFL_SEL_OFF) begin
        tx_halt <= 1'b0;
      end else if (rx_char_valid && hit_pause) begin
        tx_halt <= 1'b1;
      end else if (rx_char_valid && hit_resume) begin
        tx_halt <= 1'b0;
      end
      if (rx_char_valid) begin
        prev_pause1_ff  <= rx_seq && eq_p1;
        prev_resume1_ff <= rx_seq && eq_r1;
      end
    end
  end

endmodule

//--- dv/usffl_core_checker.sv
// Purpose: Port-level assertions for the soft flow control block.
// Assumes: Bound onto every usffl_core instance, one clock domain.
// Notes:   Fill counts are mirrored here from the push and pop pulses.
`timescale 1ns/100ps
`include "usffl_consts.vh"

module usffl_core_checker #(
  parameter CNT_W = 8
) (
  // Clock and reset.
  input wire       ref_clk,
  input wire       rst_n,
  // Register port.
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // FIFO events and line characters.
  input wire       tx_push,
  input wire       tx_pop,
  input wire       rx_push,
  input wire       rx_pop,
  input wire       rx_char_valid,
  input wire [7:0] rx_char_data,
  // Flow characters and status.
  input wire       flow_char_valid,
  input wire [7:0] flow_char_data,
  input wire       flow_char_taken,
  input wire       tx_halt,
  input wire       rx_flow_hit,
  input wire       tx_at_trigger,
  input wire       rx_at_trigger
);
  reg [7:0] tx_cnt_ff;
  reg [7:0] rx_cnt_ff;

  // Next count; a push into a full FIFO or a pop from an empty one is dropped
  // first, and only the events that remain cancel each other.
  function automatic [7:0] step_cnt(input [7:0] c, input p, input q);
    reg inc;
    reg dec;
    inc = p && (c < `USFFL_FIFO_DEPTH);
    dec = q && (c != 8'h00);
    step_cnt = c + {7'h00, inc && !dec} - {7'h00, dec && !inc};
  endfunction

  // Mirror both fill counts so reads can be judged without a bench model.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_cnt_ff <= 8'h00;
      rx_cnt_ff <= 8'h00;
    end else begin
      tx_cnt_ff <= step_cnt(tx_cnt_ff, tx_push, tx_pop);
      rx_cnt_ff <= step_cnt(rx_cnt_ff, rx_push, rx_pop);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_rx_count: assert property (reg_rd && reg_addr == `USFFL_OFF_RX_LVL |=>
    reg_rdata == $past(rx_cnt_ff)) else $error("receive count read wrong");
  a_tx_count: assert property (reg_rd && reg_addr == `USFFL_OFF_TX_CNT |=>
    reg_rdata == $past(tx_cnt_ff)) else $error("transmit count read wrong");
  a_status_rsvd: assert property (reg_rd && reg_addr == `USFFL_OFF_PAUSE1 |=>
    reg_rdata[7:4] == 4'h0) else $error("status reserved bits set");
  a_unmapped_zero: assert property (reg_rd && reg_addr > `USFFL_OFF_TX_CNT |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_offer_hold: assert property (flow_char_valid && !flow_char_taken |=>
    flow_char_valid && $stable(flow_char_data)) else $error("offer dropped early");
  a_hit_cause: assert property (rx_flow_hit |-> $past(rx_char_valid))
    else $error("match without character");
  a_halt_cause: assert property ($rose(tx_halt) |-> rx_flow_hit)
    else $error("halt without match");
  a_halt_hold: assert property (tx_halt && !rx_char_valid && !reg_wr && !$past(reg_wr)
    |=> tx_halt) else $error("halt released without cause");

  c_taken: cover property (flow_char_valid && flow_char_taken);
  c_halt: cover property ($rose(tx_halt));
  c_full: cover property (rx_cnt_ff == `USFFL_FIFO_DEPTH && rx_push);
endmodule

bind usffl_core usffl_core_checker #(.CNT_W(CNT_W)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_push(tx_push),
  .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop), .rx_char_valid(rx_char_valid),
  .rx_char_data(rx_char_data), .flow_char_valid(flow_char_valid),
  .flow_char_data(flow_char_data), .flow_char_taken(flow_char_taken), .tx_halt(tx_halt),
  .rx_flow_hit(rx_flow_hit), .tx_at_trigger(tx_at_trigger), .rx_at_trigger(rx_at_trigger));

//--- dv/usffl_remote.sv
// Purpose: Remote serial partner taking flow characters and sending line characters.
// Assumes: The bench sets lag to make the line slow or prompt.
// Notes:   Received data shows the inverse of the last character when idle.
`timescale 1ns/100ps

module usffl_remote (
  // Clock and reset.
  input  wire       ref_clk,
  input  wire       rst_n,
  // Flow characters offered by the block.
  input  wire       flow_char_valid,
  input  wire [7:0] flow_char_data,
  output reg        flow_char_taken = 1'b0,
  // Characters arriving from the line.
  output reg        rx_char_valid   = 1'b0,
  output reg  [7:0] rx_char_data    = 8'h00
);
  int         lag = 0;
  int         wait_cnt = 0;
  logic [7:0] got_q[$];

  // Take each offer after lag cycles, as a slow line would, and log it.
  always @(posedge ref_clk) begin
    flow_char_taken <= 1'b0;
    if (!rst_n) begin
      wait_cnt = 0;
    end else if (flow_char_valid && !flow_char_taken) begin
      if (wait_cnt >= lag) begin
        flow_char_taken <= 1'b1;
        got_q.push_back(flow_char_data);
        wait_cnt = 0;
      end else begin
        wait_cnt++;
      end
    end
  end

  // One character for one cycle; the data then flips so a stale value never matches.
  task send(input logic [7:0] c);
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_char_data <= c;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~c;
  endtask
endmodule

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the soft flow control and FIFO level block.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes:   Each table row starts from a fresh reset, since the status is sticky.
`timescale 1ns/100ps
`include "usffl_consts.vh"

module tb_top;
  typedef struct {logic [3:0] sel; int n; logic [15:0] p; logic [7:0] s1;
                  logic [15:0] r; logic [7:0] s2;} usffl_tx_t;
  typedef struct {logic [3:0] sel; logic [31:0] cs; logic [1:0] h;} usffl_rx_t;

  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       tx_push = 1'b0;
  logic       tx_pop = 1'b0;
  logic       rx_push = 1'b0;
  logic       rx_pop = 1'b0;
  logic       rx_char_valid;
  logic [7:0] rx_char_data;
  logic       flow_char_valid;
  logic [7:0] flow_char_data;
  logic       flow_char_taken;
  logic       tx_halt;
  logic       rx_flow_hit;
  logic       tx_at_trigger;
  logic       rx_at_trigger;
  int         failures = 0;
  int         comparisons = 0;

  // Pause characters sent once select is written, resume once rx trigger rises above 0.
  usffl_tx_t tx_rows[8] = '{
    '{4'b1000, 1, 16'ha100, 8'h01, 16'hc300, 8'h02},
    '{4'b0100, 1, 16'hb200, 8'h04, 16'hd400, 8'h08},
    '{4'b1100, 2, 16'ha1b2, 8'h05, 16'hc3d4, 8'h0a},
    '{4'b0000, 0, 16'h0000, 8'h00, 16'h0000, 8'h00},
    '{4'b1011, 1, 16'ha100, 8'h01, 16'hc300, 8'h02},
    '{4'b0111, 1, 16'hb200, 8'h04, 16'hd400, 8'h08},
    '{4'b1111, 2, 16'ha1b2, 8'h05, 16'hc3d4, 8'h0a},
    '{4'b0011, 0, 16'h0000, 8'h00, 16'h0000, 8'h00}};
  // Four line characters; halt checked against h after the second and after the fourth.
  usffl_rx_t rx_rows[9] = '{
    '{4'b0010, 32'ha155c355, 2'b10}, '{4'b0001, 32'hb255d455, 2'b10},
    '{4'b0001, 32'ha1c35555, 2'b00}, '{4'b1011, 32'hb255c355, 2'b10},
    '{4'b0111, 32'ha155d455, 2'b10}, '{4'b0000, 32'ha1555555, 2'b00},
    '{4'b0011, 32'ha1b2c3d4, 2'b10}, '{4'b0011, 32'ha1555555, 2'b00},
    '{4'b1111, 32'ha1b2c3d4, 2'b10}};

  usffl_core dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_push(tx_push),
    .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .flow_char_valid(flow_char_valid),
    .flow_char_data(flow_char_data), .flow_char_taken(flow_char_taken), .tx_halt(tx_halt),
    .rx_flow_hit(rx_flow_hit), .tx_at_trigger(tx_at_trigger), .rx_at_trigger(rx_at_trigger));

  usffl_remote remote_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .flow_char_valid(flow_char_valid),
    .flow_char_data(flow_char_data), .flow_char_taken(flow_char_taken),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data));

  // Clock and watchdog; the run needs a few thousand cycles at most.
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task reset_dut(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task expect_reg(input logic [4:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task fifo_ev(input logic [3:0] ev, input int n);
    @(posedge ref_clk);
    {tx_push, tx_pop, rx_push, rx_pop} <= ev;
    repeat (n) @(posedge ref_clk);
    {tx_push, tx_pop, rx_push, rx_pop} <= 4'h0;
  endtask
  task setup(input logic [3:0] sel);
    reset_dut(2);
    remote_u.got_q.delete();
    wr(`USFFL_OFF_PAUSE1, 8'ha1);
    wr(`USFFL_OFF_PAUSE2, 8'hb2);
    wr(`USFFL_OFF_RESUME1, 8'hc3);
    wr(`USFFL_OFF_RESUME2, 8'hd4);
    wr(`USFFL_OFF_FEATURE, {4'h0, sel});
  endtask
  // Bounded wait for n taken characters, then a margin to catch extra ones.
  task settle(input int n);
    for (int k = 0; k < 40 && remote_u.got_q.size() < n; k++) @(posedge ref_clk);
    repeat (6) @(posedge ref_clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    usffl_tx_t tr;
    usffl_rx_t rr;
    reset_dut(10);
    expect_reg(`USFFL_OFF_FEATURE, 8'h00);
    expect_reg(`USFFL_OFF_PAUSE1, 8'h00);
    expect_reg(5'h1f, 8'h00);
    wr(`USFFL_OFF_FEATURE, 8'h50);
    expect_reg(`USFFL_OFF_FEATURE, 8'h50);
    $display("reset and register tests done");
    foreach (tx_rows[i]) begin
      tr = tx_rows[i];
      remote_u.lag = i % 3;
      setup(tr.sel);
      settle(tr.n);
      chk(8'(remote_u.got_q.size()), 8'(tr.n));
      for (int k = 0; k < tr.n; k++) chk(remote_u.got_q[k], tr.p[15-8*k -: 8]);
      expect_reg(`USFFL_OFF_PAUSE1, tr.s1);
      remote_u.got_q.delete();
      wr(`USFFL_OFF_RX_LVL, 8'h05);
      settle(tr.n);
      for (int k = 0; k < tr.n; k++) chk(remote_u.got_q[k], tr.r[15-8*k -: 8]);
      expect_reg(`USFFL_OFF_PAUSE1, tr.s2);
      $display("tx row %0d done", i);
    end
    foreach (rx_rows[i]) begin
      rr = rx_rows[i];
      setup(rr.sel);
      for (int k = 0; k < 4; k++) begin
        remote_u.send(rr.cs[31-8*k -: 8]);
        if (k % 2 == 1) #1 chk(tx_halt, rr.h[1-k/2]);
      end
      $display("rx row %0d done", i);
    end
    // A pause character left at its reset value of zero still matches.
    reset_dut(2);
    wr(`USFFL_OFF_FEATURE, 8'h02);
    remote_u.send(8'h00);
    #1 chk(tx_halt, 1'b1);
    chk(rx_flow_hit, 1'b1);
    $display("zero character test done");
    // Over-limit trigger is clamped, so a full FIFO reaches it; extra pushes are lost.
    reset_dut(2);
    wr(`USFFL_OFF_RX_LVL, 8'h41);
    fifo_ev(4'b0010, 65);
    repeat (2) @(posedge ref_clk);
    #1 chk(rx_at_trigger, 1'b1);
    expect_reg(`USFFL_OFF_RX_LVL, 8'h40);
    fifo_ev(4'b0001, 1);
    repeat (2) @(posedge ref_clk);
    #1 chk(rx_at_trigger, 1'b0);
    expect_reg(`USFFL_OFF_RX_LVL, 8'h3f);
    // Transmit count ignores writes and a simultaneous push and pop.
    wr(`USFFL_OFF_TX_TRIG, 8'h02);
    wr(`USFFL_OFF_TX_CNT, 8'h33);
    fifo_ev(4'b1000, 3);
    fifo_ev(4'b1100, 1);
    repeat (2) @(posedge ref_clk);
    #1 chk(tx_at_trigger, 1'b0);
    expect_reg(`USFFL_OFF_TX_CNT, 8'h03);
    fifo_ev(4'b0100, 1);
    repeat (2) @(posedge ref_clk);
    #1 chk(tx_at_trigger, 1'b1);
    $display("fifo level tests done");
    summarize();
  end
endmodule
